// ---- design/dcr_pkg.sv ----
// constants for the cpu register file with dsp pointer roles
// assumes a single aclk domain and a 12-bit axi4-lite byte address
package dcr_pkg;
   localparam int          DATA_W        = 32;
   localparam int          NUM_GPR       = 16;
   localparam int          NUM_CR        = 6;
   localparam int          ADDR_W        = 12;
   localparam logic [3:0]  IDX_R0        = 4'h0;
   localparam logic [3:0]  IDX_STACK     = 4'hf;
   localparam logic [3:0]  IDX_X0        = 4'h4;
   localparam logic [3:0]  IDX_Y0        = 4'h6;
   localparam logic [3:0]  IDX_XIDX      = 4'h8;
   localparam logic [3:0]  IDX_YIDX      = 4'h9;
   localparam logic [3:0]  IDX_S0        = 4'h2;
   localparam logic [3:0]  IDX_SIDX      = 4'h8;
   localparam logic [31:0] STACK_FRAME   = 32'h0000_0008;
   localparam logic [11:0] OFF_GPR_BASE  = 12'h000;
   localparam logic [11:0] OFF_CR_BASE   = 12'h040;
   localparam logic [11:0] OFF_CR_LAST   = 12'h054;
   localparam logic [31:0] SW_KEEP_MASK  = 32'h0fff_0fff;
   localparam logic [31:0] SW_RESET      = 32'h0000_0000;
   localparam logic [31:0] CR_RESET      = 32'h0000_0000;
   localparam logic [31:0] GPR_RESET     = 32'h0000_0000;
   localparam int          SW_CNT_LSB    = 16;
   localparam int          SW_CNT_MSB    = 27;
   localparam int          SW_YCIRC_BIT  = 11;
   localparam int          SW_XCIRC_BIT  = 10;
   localparam int          BND_END_LSB   = 16;
   localparam logic [1:0]  RESP_OKAY     = 2'b00;
   localparam logic [1:0]  RESP_SLVERR   = 2'b10;
   localparam logic [4:0]  MAP_MISS      = 5'h1f;
   typedef enum logic [2:0] {
      CR_STATUS = 3'b000,
      CR_LSTART = 3'b001,
      CR_LEND   = 3'b010,
      CR_GBASE  = 3'b011,
      CR_VBASE  = 3'b100,
      CR_BOUNDS = 3'b101
   } dcr_cr_sel_t;
endpackage

// ---- design/dcr_step_if.sv ----
// carrier between the register file and a pointer step unit
// assumes both ends sit in the aclk domain
`timescale 1ns/1ps
`default_nettype none
interface dcr_step_if;
   logic [31:0] ptr;
   logic [31:0] inc;
   logic        circ_en;
   logic [15:0] buf_start;
   logic [15:0] buf_end;
   logic [31:0] nxt;
   modport unit (input ptr, input inc, input circ_en, input buf_start, input buf_end,
                 output nxt);
   modport user (output ptr, output inc, output circ_en, output buf_start,
                 output buf_end, input nxt);
endinterface
`default_nettype wire

// ---- design/dcr_ptr_step.sv ----
// post-increment of one data pointer with optional circular wrap
// assumes buffer bounds compare on the low 16 address bits only
`timescale 1ns/1ps
`default_nettype none
module dcr_ptr_step (
   dcr_step_if.unit st
);
   logic [31:0] sum;
   always_comb begin
      sum    = st.ptr + st.inc;
      st.nxt = sum;
      // upper half comes from the full sum, so a carry out of bit 15 can leave the 64k page
      if (st.circ_en && (sum[15:0] > st.buf_end)) begin
         st.nxt = {sum[31:16], st.buf_start};
      end
   end
endmodule
`default_nettype wire

// ---- design/dcr_regfile.sv ----
// cpu register file: general, control, dsp pointer roles, axi4-lite window
// assumes decode drives one write per port per cycle, same aclk domain
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dcr_regfile
   import dcr_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [3:0]        rd_a_addr,
   output logic [31:0]            rd_a_data,
   input  wire logic [3:0]        rd_b_addr,
   output logic [31:0]            rd_b_data,
   input  wire logic              gpr_we,
   input  wire logic [3:0]        gpr_waddr,
   input  wire logic [31:0]       gpr_wdata,
   input  wire logic              cr_we,
   input  wire logic [2:0]        cr_wsel,
   input  wire logic [31:0]       cr_wdata,
   input  wire logic [2:0]        cr_rsel,
   output logic [31:0]            cr_rdata,
   output logic [31:0]            index_r0,
   output logic [31:0]            hardware_stack_pointer,
   input  wire logic              exc_push,
   input  wire logic [31:0]       exc_pc,
   input  wire logic              exc_pop,
   input  wire logic [31:0]       exc_pop_status,
   output logic [31:0]            frame_addr,
   output logic [31:0]            frame_status,
   output logic [31:0]            frame_pc,
   input  wire logic              x_ptr_sel,
   input  wire logic              y_ptr_sel,
   input  wire logic              x_upd_en,
   input  wire logic              y_upd_en,
   output logic [31:0]            x_addr_pointer,
   output logic [31:0]            y_addr_pointer,
   output logic [31:0]            x_index_reg,
   output logic [31:0]            y_index_reg,
   input  wire logic [1:0]        s_ptr_sel,
   input  wire logic              s_upd_en,
   output logic [31:0]            single_data_pointer,
   output logic [31:0]            single_data_index_reg,
   input  wire logic [31:0]       gbase_disp,
   output logic [31:0]            gbase_addr,
   input  wire logic [31:0]       vector_offset,
   output logic [31:0]            vector_addr,
   input  wire logic              loop_dec,
   output logic [11:0]            loop_count_field,
   output logic [31:0]            loop_start_pointer,
   output logic [31:0]            loop_end_pointer,
   output logic                   x_circular_enable,
   output logic                   y_circular_enable
);
   logic [31:0] gpr_q [NUM_GPR];
   logic [31:0] gpr_d [NUM_GPR];
   logic [31:0] cr_q  [NUM_CR];
   logic [31:0] cr_d  [NUM_CR];
   logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] frame_addr_q, frame_addr_d, frame_status_q, frame_status_d;
   logic [31:0] frame_pc_q, frame_pc_d;
   logic        aw_take, ar_take;
   logic [4:0]  aw_map, ar_map;
   logic [3:0]  x_idx, y_idx, s_idx;
   logic [31:0] stk_ptr, s_next, status, bounds;
   dcr_step_if  x_st ();
   dcr_step_if  y_st ();

   // 0..15 general, 16..21 control, else unmapped
   function automatic logic [4:0] map_addr(input logic [ADDR_W-1:0] a);
      logic [11:0] off;
      off = 12'(a);
      if (off < OFF_CR_BASE) begin
         return {1'b0, off[5:2]};
      end else if (off <= OFF_CR_LAST) begin
         return 5'h10 + 5'((off - OFF_CR_BASE) >> 2);
      end else begin
         return MAP_MISS;
      end
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   assign status = cr_q[CR_STATUS];
   assign bounds = cr_q[CR_BOUNDS];
   assign stk_ptr = gpr_q[IDX_STACK];
   assign x_idx  = IDX_X0 + {3'b000, x_ptr_sel};
   assign y_idx  = IDX_Y0 + {3'b000, y_ptr_sel};
   assign s_idx  = IDX_S0 + {2'b00, s_ptr_sel};

   // separate read paths so x and y fetch in one cycle
   assign x_addr_pointer        = gpr_q[x_idx];
   assign y_addr_pointer        = gpr_q[y_idx];
   assign x_index_reg           = gpr_q[IDX_XIDX];
   assign y_index_reg           = gpr_q[IDX_YIDX];
   assign single_data_pointer   = gpr_q[s_idx];
   assign single_data_index_reg = gpr_q[IDX_SIDX];
   assign index_r0              = gpr_q[IDX_R0];
   assign hardware_stack_pointer = stk_ptr;
   assign rd_a_data             = gpr_q[rd_a_addr];
   assign rd_b_data             = gpr_q[rd_b_addr];
   assign cr_rdata              = (cr_rsel < 3'(NUM_CR)) ? cr_q[cr_rsel] : 32'h0000_0000;
   assign gbase_addr            = cr_q[CR_GBASE] + gbase_disp;
   assign vector_addr           = cr_q[CR_VBASE] + vector_offset;
   assign loop_count_field      = status[SW_CNT_MSB:SW_CNT_LSB];
   assign loop_start_pointer    = cr_q[CR_LSTART];
   assign loop_end_pointer      = cr_q[CR_LEND];
   assign x_circular_enable     = status[SW_XCIRC_BIT];
   assign y_circular_enable     = status[SW_YCIRC_BIT];
   assign frame_addr            = frame_addr_q;
   assign frame_status          = frame_status_q;
   assign frame_pc              = frame_pc_q;

   assign x_st.ptr       = x_addr_pointer;
   assign x_st.inc       = x_index_reg;
   assign x_st.circ_en   = x_circular_enable;
   assign x_st.buf_start = bounds[BND_END_LSB-1:0];
   assign x_st.buf_end   = bounds[31:BND_END_LSB];
   assign y_st.ptr       = y_addr_pointer;
   assign y_st.inc       = y_index_reg;
   assign y_st.circ_en   = y_circular_enable;
   assign y_st.buf_start = bounds[BND_END_LSB-1:0];
   assign y_st.buf_end   = bounds[31:BND_END_LSB];
   // single transfers bypass the wrap unit entirely
   assign s_next         = single_data_pointer + single_data_index_reg;

   dcr_ptr_step u_x_step (.st(x_st.unit));
   dcr_ptr_step u_y_step (.st(y_st.unit));

   assign aw_take       = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
   assign ar_take       = s_axi_arvalid && !rvalid_q;
   assign s_axi_awready = aw_take;
   assign s_axi_wready  = aw_take;
   assign s_axi_arready = ar_take;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign aw_map        = map_addr(s_axi_awaddr);
   assign ar_map        = map_addr(s_axi_araddr);

   // write priority, lowest first: bus, pointer steps, stack, instruction port
   always_comb begin
      for (int i = 0; i < NUM_GPR; i++) begin
         gpr_d[i] = gpr_q[i];
      end
      if (aw_take && !aw_map[4]) begin
         gpr_d[aw_map[3:0]] = merge(gpr_q[aw_map[3:0]], s_axi_wdata, s_axi_wstrb);
      end
      if (s_upd_en) begin
         gpr_d[s_idx] = s_next;
      end
      if (x_upd_en) begin
         gpr_d[x_idx] = x_st.nxt;
      end
      if (y_upd_en) begin
         gpr_d[y_idx] = y_st.nxt;
      end
      if (exc_push) begin
         gpr_d[IDX_STACK] = stk_ptr - STACK_FRAME;
      end else if (exc_pop) begin
         gpr_d[IDX_STACK] = stk_ptr + STACK_FRAME;
      end
      if (gpr_we) begin
         gpr_d[gpr_waddr] = gpr_wdata;
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_CR; i++) begin
         cr_d[i] = cr_q[i];
      end
      if (aw_take && (aw_map >= 5'h10) && (aw_map != MAP_MISS)) begin
         cr_d[3'(aw_map - 5'h10)] = merge(cr_q[3'(aw_map - 5'h10)], s_axi_wdata, s_axi_wstrb);
      end
      if (loop_dec && (loop_count_field != 12'h000)) begin
         cr_d[CR_STATUS][SW_CNT_MSB:SW_CNT_LSB] = loop_count_field - 12'h001;
      end
      if (exc_pop) begin
         cr_d[CR_STATUS] = exc_pop_status;
      end
      if (cr_we && (cr_wsel < 3'(NUM_CR))) begin
         cr_d[cr_wsel] = cr_wdata;
      end
      cr_d[CR_STATUS] = cr_d[CR_STATUS] & SW_KEEP_MASK;
   end

   always_comb begin
      frame_addr_d   = frame_addr_q;
      frame_status_d = frame_status_q;
      frame_pc_d     = frame_pc_q;
      if (exc_push) begin
         frame_addr_d   = stk_ptr - STACK_FRAME;
         frame_status_d = status;
         frame_pc_d     = exc_pc;
      end
   end

   always_comb begin
      bvalid_d = bvalid_q;
      bresp_d  = bresp_q;
      rvalid_d = rvalid_q;
      rresp_d  = rresp_q;
      rdata_d  = rdata_q;
      if (aw_take) begin
         bvalid_d = 1'b1;
         bresp_d  = (aw_map == MAP_MISS) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (ar_take) begin
         rvalid_d = 1'b1;
         if (ar_map == MAP_MISS) begin
            rresp_d = RESP_SLVERR;
            rdata_d = 32'h0000_0000;
         end else if (!ar_map[4]) begin
            rresp_d = RESP_OKAY;
            rdata_d = gpr_q[ar_map[3:0]];
         end else begin
            rresp_d = RESP_OKAY;
            rdata_d = cr_q[3'(ar_map - 5'h10)];
         end
      end else if (s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_GPR; i++) begin
            gpr_q[i] <= GPR_RESET;
         end
         for (int i = 0; i < NUM_CR; i++) begin
            cr_q[i] <= CR_RESET;
         end
         cr_q[CR_STATUS] <= SW_RESET;
         bvalid_q        <= 1'b0;
         bresp_q         <= RESP_OKAY;
         rvalid_q        <= 1'b0;
         rresp_q         <= RESP_OKAY;
         rdata_q         <= 32'h0000_0000;
         frame_addr_q    <= 32'h0000_0000;
         frame_status_q  <= 32'h0000_0000;
         frame_pc_q      <= 32'h0000_0000;
      end else begin
         gpr_q          <= gpr_d;
         cr_q           <= cr_d;
         bvalid_q       <= bvalid_d;
         bresp_q        <= bresp_d;
         rvalid_q       <= rvalid_d;
         rresp_q        <= rresp_d;
         rdata_q        <= rdata_d;
         frame_addr_q   <= frame_addr_d;
         frame_status_q <= frame_status_d;
         frame_pc_q     <= frame_pc_d;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_WRITE_VISIBLE: assert property (
      gpr_we ##1 (rd_a_addr == $past(gpr_waddr)) |-> rd_a_data == $past(gpr_wdata))
      else $error("general write not visible next cycle");
   AST_STATUS_ZERO: assert property ((status & ~SW_KEEP_MASK) == 32'h0000_0000)
      else $error("status reserved bits not zero");
   AST_PUSH_SP: assert property (
      exc_push && !(gpr_we && gpr_waddr == IDX_STACK) |=> stk_ptr == $past(stk_ptr) - STACK_FRAME
         && frame_addr == stk_ptr)
      else $error("stack push did not drop stack pointer by frame");
   AST_POP_STATUS: assert property (
      exc_pop && !cr_we |=> status == ($past(exc_pop_status) & SW_KEEP_MASK))
      else $error("status not restored on pop");
   AST_SINGLE_NO_WRAP: assert property (
      s_upd_en && !gpr_we && !x_upd_en && !y_upd_en && !exc_push && !exc_pop
         && s_idx != IDX_STACK |=> gpr_q[$past(s_idx)] == $past(s_next))
      else $error("single pointer step wrong");
   AST_X_WRAP: assert property (
      x_upd_en && !gpr_we && x_circular_enable
         && (x_addr_pointer[15:0] + x_index_reg[15:0] > bounds[31:16])
         |=> gpr_q[$past(x_idx)][15:0] == $past(bounds[15:0]))
      else $error("x pointer did not reload buffer start");
   AST_LOOP_DEC: assert property (
      loop_dec && loop_count_field != 12'h000 && !cr_we && !exc_pop && !aw_take
         |=> loop_count_field == $past(loop_count_field) - 12'h001)
      else $error("loop count did not step down");
   AST_VECTOR: assert property (
      cr_we && cr_wsel == CR_VBASE ##1 !cr_we |-> vector_addr == $past(cr_wdata) + vector_offset)
      else $error("vector address not from vector base");
   AST_BUS_MISS: assert property (
      aw_take && aw_map == MAP_MISS |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
endmodule
`default_nettype wire

// ---- tb/dcr_decode_model.sv ----
// partner: instruction decode side that issues register-file writes
// assumes aclk domain; every call starts just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module dcr_decode_model (
   input  wire logic        aclk,
   output logic             gpr_we,
   output logic [3:0]       gpr_waddr,
   output logic [31:0]      gpr_wdata,
   output logic             cr_we,
   output logic [2:0]       cr_wsel,
   output logic [31:0]      cr_wdata
);
   initial begin
      gpr_we = 1'b0;
      gpr_waddr = 4'h0;
      gpr_wdata = 32'h0;
      cr_we = 1'b0;
      cr_wsel = 3'h0;
      cr_wdata = 32'h0;
   end
   task automatic wr_gpr(input logic [3:0] a, input logic [31:0] d);
      @(posedge aclk);
      gpr_waddr <= a;
      gpr_wdata <= d;
      gpr_we <= 1'b1;
      @(posedge aclk);
      gpr_we <= 1'b0;
   endtask
   task automatic wr_cr(input logic [2:0] s, input logic [31:0] d);
      // software side: never both circular enables at once
      @(posedge aclk);
      cr_wdata <= (s == 3'h0 && d[11] && d[10]) ? (d & ~32'h800) : d;
      cr_wsel <= s;
      cr_we <= 1'b1;
      @(posedge aclk);
      cr_we <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- tb/test_dsp_cpu_register_file.sv ----
// bench for the register file: axi4-lite master, decode model, dsp ports
// assumes 100 MHz aclk and synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module test_dsp_cpu_register_file;
   import dcr_pkg::*;
   logic aclk = 0, aresetn = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, gpr_we, cr_we, exc_push = 0, exc_pop = 0, loop_dec = 0;
   logic x_ptr_sel = 0, y_ptr_sel = 0, x_upd_en = 0, y_upd_en = 0, s_upd_en = 0;
   logic x_circular_enable, y_circular_enable;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, gpr_wdata, cr_wdata, exc_pc = 0;
   logic [31:0] exc_pop_status = 0, gbase_disp = 0, vector_offset = 0;
   logic [31:0] rd_a_data, rd_b_data, cr_rdata, index_r0, hardware_stack_pointer;
   logic [31:0] frame_addr, frame_status, frame_pc, x_addr_pointer, y_addr_pointer;
   logic [31:0] x_index_reg, y_index_reg, single_data_pointer, single_data_index_reg;
   logic [31:0] gbase_addr, vector_addr, loop_start_pointer, loop_end_pointer;
   logic [3:0] s_axi_wstrb = 4'hf, rd_a_addr = 0, rd_b_addr = 0, gpr_waddr;
   logic [2:0] cr_wsel, cr_rsel = 0;
   logic [1:0] s_axi_bresp, s_axi_rresp, s_ptr_sel = 0, rsp;
   logic [11:0] loop_count_field;
   logic [31:0] rd;
   int err_total = 0, comparisons = 0;
   always #5 aclk = ~aclk;
   dcr_decode_model i_dec (.aclk, .gpr_we, .gpr_waddr, .gpr_wdata, .cr_we, .cr_wsel,
      .cr_wdata);
   dcr_regfile i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rd_a_addr, .rd_a_data, .rd_b_addr,
      .rd_b_data, .gpr_we, .gpr_waddr, .gpr_wdata, .cr_we, .cr_wsel, .cr_wdata, .cr_rsel,
      .cr_rdata, .index_r0, .hardware_stack_pointer, .exc_push, .exc_pc, .exc_pop,
      .exc_pop_status, .frame_addr, .frame_status, .frame_pc, .x_ptr_sel, .y_ptr_sel,
      .x_upd_en, .y_upd_en, .x_addr_pointer, .y_addr_pointer, .x_index_reg, .y_index_reg,
      .s_ptr_sel, .s_upd_en, .single_data_pointer, .single_data_index_reg, .gbase_disp,
      .gbase_addr, .vector_offset, .vector_addr, .loop_dec, .loop_count_field,
      .loop_start_pointer, .loop_end_pointer, .x_circular_enable, .y_circular_enable);
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // both channels offered together; each released once taken
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic t_bus();
      axi_rd(12'h040, rd, rsp);
      chk("status after reset", rd, 32'h0);
      axi_wr(12'h044, 32'ha5a5_5a5a, rsp);
      chk("write resp", {30'h0, rsp}, 32'h0);
      axi_rd(12'h044, rd, rsp);
      chk("loop start readback", rd, 32'ha5a5_5a5a);
      chk("loop start port", loop_start_pointer, 32'ha5a5_5a5a);
      axi_wr(12'h058, 32'h1, rsp);
      chk("unmapped write resp", {30'h0, rsp}, 32'h2);
      axi_rd(12'h058, rd, rsp);
      chk("unmapped read resp", {30'h0, rsp}, 32'h2);
      chk("unmapped read data", rd, 32'h0);
      $display("done t_bus");
   endtask
   task automatic t_gpr();
      for (int i = 0; i < 16; i++) begin
         i_dec.wr_gpr(i[3:0], 32'h1111_1111 * i);
         rd_a_addr <= i[3:0];
         rd_b_addr <= 4'hf - i[3:0];
         #1;
         chk("gpr port a", rd_a_data, 32'h1111_1111 * i);
      end
      chk("gpr port b", rd_b_data, 32'h0);
      chk("index r0", index_r0, 32'h0);
      chk("stack pointer", hardware_stack_pointer, 32'hffff_ffff);
      $display("done t_gpr");
   endtask
   task automatic t_roles();
      for (int k = 0; k < 4; k++) begin
         @(posedge aclk);
         x_ptr_sel <= k[0];
         y_ptr_sel <= k[0];
         s_ptr_sel <= k[1:0];
         #1;
         chk("x pointer", x_addr_pointer, 32'h1111_1111 * (4 + k[0]));
         chk("y pointer", y_addr_pointer, 32'h1111_1111 * (6 + k[0]));
         chk("single pointer", single_data_pointer, 32'h1111_1111 * (k + 2));
      end
      chk("x index", x_index_reg, 32'h8888_8888);
      chk("y index", y_index_reg, 32'h9999_9999);
      chk("single index", single_data_index_reg, 32'h8888_8888);
      $display("done t_roles");
   endtask
   task automatic t_stack();
      @(posedge aclk);
      exc_pc <= 32'h0000_2000;
      exc_push <= 1'b1;
      @(posedge aclk);
      exc_push <= 1'b0;
      #1;
      chk("stack ptr after push", hardware_stack_pointer, 32'hffff_fff7);
      chk("frame addr", frame_addr, 32'hffff_fff7);
      chk("frame pc", frame_pc, 32'h0000_2000);
      chk("frame status", frame_status, 32'h0000_0000);
      @(posedge aclk);
      exc_pop_status <= 32'hffff_ffff;
      exc_pop <= 1'b1;
      cr_rsel <= 3'h0;
      @(posedge aclk);
      exc_pop <= 1'b0;
      #1;
      chk("stack ptr after pop", hardware_stack_pointer, 32'hffff_ffff);
      chk("status masked", cr_rdata, 32'h0fff_0fff);
      axi_rd(12'h040, rd, rsp);
      chk("status bus read", rd, 32'h0fff_0fff);
      // second push carries the restored, nonzero status into the frame
      @(posedge aclk);
      exc_pc <= 32'h0000_3000;
      exc_push <= 1'b1;
      @(posedge aclk);
      exc_push <= 1'b0;
      #1;
      chk("frame status again", frame_status, 32'h0fff_0fff);
      chk("frame pc again", frame_pc, 32'h0000_3000);
      $display("done t_stack");
   endtask
   task automatic t_loop();
      i_dec.wr_cr(3'h0, 32'h0003_0000);
      #1;
      i_dec.wr_cr(3'h2, 32'h0000_0120);
      #1;
      chk("loop end", loop_end_pointer, 32'h0000_0120);
      chk("count field", {20'h0, loop_count_field}, 32'h3);
      for (int n = 2; n >= -1; n--) begin
         @(posedge aclk);
         loop_dec <= 1'b1;
         @(posedge aclk);
         loop_dec <= 1'b0;
         #1;
         chk("count after dec", {20'h0, loop_count_field}, (n < 0) ? 32'h0 : n);
      end
      $display("done t_loop");
   endtask
   task automatic t_circ();
      axi_wr(12'h054, 32'h0010_0004, rsp);
      i_dec.wr_cr(3'h0, 32'h0000_0400);
      #1;
      chk("x circ enable", {31'h0, x_circular_enable}, 32'h1);
      chk("y circ enable", {31'h0, y_circular_enable}, 32'h0);
      i_dec.wr_gpr(4'h4, 32'h1234_000c);
      #1;
      i_dec.wr_gpr(4'h8, 32'h0000_0008);
      x_ptr_sel <= 1'b0;
      y_ptr_sel <= 1'b0;
      s_ptr_sel <= 2'h2;
      x_upd_en <= 1'b1;
      y_upd_en <= 1'b1;
      @(posedge aclk);
      x_upd_en <= 1'b0;
      y_upd_en <= 1'b0;
      #1;
      chk("x wrapped", x_addr_pointer, 32'h1234_0004);
      chk("y no wrap", y_addr_pointer, 32'hffff_ffff);
      for (int k = 1; k <= 2; k++) begin
         @(posedge aclk);
         s_upd_en <= 1'b1;
         @(posedge aclk);
         s_upd_en <= 1'b0;
         #1;
         chk("single no wrap", single_data_pointer, 32'h1234_0004 + 8 * k);
      end
      // swap the enables: y now wraps, x runs straight past the end
      i_dec.wr_cr(3'h0, 32'h0000_0800);
      i_dec.wr_gpr(4'h6, 32'h5678_000e);
      i_dec.wr_gpr(4'h9, 32'h0000_0004);
      x_upd_en <= 1'b1;
      y_upd_en <= 1'b1;
      @(posedge aclk);
      x_upd_en <= 1'b0;
      y_upd_en <= 1'b0;
      #1;
      chk("y circ on", {31'h0, y_circular_enable}, 32'h1);
      chk("x circ off", {31'h0, x_circular_enable}, 32'h0);
      chk("y wrapped", y_addr_pointer, 32'h5678_0004);
      chk("x no wrap", x_addr_pointer, 32'h1234_001c);
      $display("done t_circ");
   endtask
   task automatic t_base();
      i_dec.wr_cr(3'h3, 32'h0000_1000);
      #1;
      i_dec.wr_cr(3'h4, 32'h8000_0000);
      gbase_disp <= 32'h24;
      vector_offset <= 32'h100;
      cr_rsel <= 3'h3;
      #1;
      chk("gbase addr", gbase_addr, 32'h0000_1024);
      chk("gbase read", cr_rdata, 32'h0000_1000);
      chk("vector addr", vector_addr, 32'h8000_0100);
      $display("done t_base");
   endtask
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_bus();
      t_gpr();
      t_roles();
      t_stack();
      t_loop();
      t_circ();
      t_base();
      stop_test();
   end
   initial begin
      repeat (5000) @(posedge aclk);
      err_total++;
      stop_test();
   end
endmodule
`default_nettype wire
